// ---- design/port_b_low_mux_invert_port_c_dir.sv ----
// Function select and inversion for port B pins 7..0, and the port C
// direction register, behind a plain 16-bit register port.
// Assumes timer outputs, GPIO data and port B direction come from
// neighbouring blocks in the mclk_i domain.
//
// Overview of operation
// - Pin B7 two-bit select, bits 15:14.
// - Pin B6 two-bit select, bits 13:12.
// - Pin B5 two-bit select, bits 11:10.
// - Pin B4 two-bit select, bits 9:8.
// - Pins B3..B0 one select bit each.
// - Odd low select bits read zero.
// - Invert bits 15:13, 11:0; bit 12 zero.
// - Inversion acts only on timer functions.
// - Set invert bit complements the pin value.
// - Invert register cleared by reset, standby.
// - Port C direction bits 4:0, rest zero.
// - Port C direction ignored for other functions.
// - Direction one drives, zero is input.
// - Direction register cleared by reset, standby.
// - Select register cleared by reset, standby.

`timescale 1ns/100ps

module port_b_low_mux_invert_port_c_dir
(
    // Clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     hw_standby_i,
    // Register port
    input  wire pinmux_pkg::reg_req_t     req_i,
    output logic [15:0]                   rdata_o,
    // Port B peripheral side
    input  wire pinmux_pkg::timer_out_t   tmr_i,
    input  wire logic [7:0]               pb_gpio_dout_i,
    input  wire logic [7:0]               pb_gpio_dir_i,
    output logic [7:0]                    pb_din_o,
    output logic [7:0]                    pb_hi_invert_o,
    // Port B pins
    input  wire logic [7:0]               pb_pin_i,
    output logic [7:0]                    pb_pin_o,
    output logic [7:0]                    pb_pin_oe_n_o,
    // Port C peripheral side
    input  wire logic [4:0]               pc_alt_func_i,
    input  wire logic [4:0]               pc_alt_drive_i,
    input  wire logic [4:0]               pc_alt_dout_i,
    input  wire logic [4:0]               pc_gpio_dout_i,
    output logic [4:0]                    pc_din_o,
    // Port C pins
    input  wire logic [4:0]               pc_pin_i,
    output logic [4:0]                    pc_pin_o,
    output logic [4:0]                    pc_pin_oe_n_o
);
    import pinmux_pkg::*;

    // ========================================================
    // Functions
    // ========================================================
    // Reserved code 11 falls to general I/O so a bad write never
    // drives a pin from an unexpected source.
    function automatic pin_func_t pin_func
    (
        input int          pin,
        input logic [15:0] sel
    );
        logic [1:0] mode;
        mode = sel[FUNC_STEP*pin +: 2];
        case (mode)
            MODE_PWM:     return (pin < WIDE_FIRST_PIN) ? FN_CH6_PWM : FN_CH7_PWM;
            MODE_ONESHOT: return (pin < WIDE_FIRST_PIN) ? FN_GPIO : FN_CH8_ONESHOT;
            default:      return FN_GPIO;
        endcase
    endfunction : pin_func

    function automatic logic wr_hit
    (
        input reg_req_t          rq,
        input logic [ADDR_W-1:0] ofs
    );
        return rq.wr && (rq.addr == ofs);
    endfunction : wr_hit

    // ========================================================
    // Registers
    // ========================================================
    logic [15:0] func_sel_r;
    logic [15:0] func_sel_nxt;
    logic [15:0] inv_r;
    logic [15:0] inv_nxt;
    logic [15:0] dir_r;
    logic [15:0] dir_nxt;
    logic [15:0] rd_word;
    logic [15:0] rdata_nxt;
    logic        reg_clr;

    // Watchdog reset is deliberately not an input: it leaves these alone.
    assign reg_clr = sys_rst_i || hw_standby_i;

    assign func_sel_nxt = wr_hit(req_i, OFS_B_FUNC)
                        ? (req_i.wdata & B_FUNC_WMASK)
                        : func_sel_r;
    assign inv_nxt      = wr_hit(req_i, OFS_B_INV)
                        ? (req_i.wdata & B_INV_WMASK)
                        : inv_r;
    assign dir_nxt      = wr_hit(req_i, OFS_C_DIR)
                        ? (req_i.wdata & C_DIR_WMASK)
                        : dir_r;

    always_ff @(posedge mclk_i)
    begin
        if (reg_clr)
        begin
            func_sel_r <= REG_RST;
            inv_r      <= REG_RST;
            dir_r      <= REG_RST;
        end
        else
        begin
            func_sel_r <= func_sel_nxt;
            inv_r      <= inv_nxt;
            dir_r      <= dir_nxt;
        end
    end

    // ========================================================
    // Read path
    // ========================================================
    // Unmapped offsets read zero; data stands one cycle only.
    assign rd_word   = (req_i.addr == OFS_B_FUNC) ? func_sel_r :
                       (req_i.addr == OFS_B_INV)  ? inv_r      :
                       (req_i.addr == OFS_C_DIR)  ? dir_r      :
                       16'h0000;
    assign rdata_nxt = req_i.rd ? rd_word : 16'h0000;

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            rdata_o <= 16'h0000;
        else
            rdata_o <= rdata_nxt;
    end

    // ========================================================
    // Port B pin mux
    // ========================================================
    pin_func_t  func   [PB_PINS];
    logic [7:0] tmr_val;
    logic [7:0] is_tmr;
    logic [7:0] pb_out_nxt;
    logic [7:0] pb_oe_n_nxt;

    for (genvar g = 0; g < PB_PINS; g++)
    begin : g_pb
        assign func[g] = pin_func(g, func_sel_r);
        if (g < WIDE_FIRST_PIN)
        begin : g_narrow
            assign tmr_val[g] = tmr_i.ch6_pwm[g];
        end
        else
        begin : g_wide
            assign tmr_val[g] = (func[g] == FN_CH8_ONESHOT)
                              ? tmr_i.ch8_oneshot[g-WIDE_FIRST_PIN]
                              : tmr_i.ch7_pwm[g-WIDE_FIRST_PIN];
        end
        assign is_tmr[g]      = (func[g] != FN_GPIO);
        assign pb_out_nxt[g]  = is_tmr[g]
                              ? (tmr_val[g] ^ inv_r[g])
                              : pb_gpio_dout_i[g];
        assign pb_oe_n_nxt[g] = is_tmr[g] ? 1'b0 : ~pb_gpio_dir_i[g];
    end

    // ========================================================
    // Port C pin control
    // ========================================================
    logic [4:0] pc_out_nxt;
    logic [4:0] pc_oe_n_nxt;

    assign pc_out_nxt  = (pc_alt_func_i & pc_alt_dout_i)
                       | (~pc_alt_func_i & pc_gpio_dout_i);
    assign pc_oe_n_nxt = ~((pc_alt_func_i & pc_alt_drive_i)
                       | (~pc_alt_func_i & dir_r[PC_PINS-1:0]));

    // ========================================================
    // Pin registers
    // ========================================================
    // Pins come up released (enables high) so nothing is driven
    // until software has chosen a function or direction.
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            pb_pin_o       <= 8'h00;
            pb_pin_oe_n_o  <= 8'hff;
            pb_din_o       <= 8'h00;
            pb_hi_invert_o <= 8'h00;
            pc_pin_o       <= 5'h00;
            pc_pin_oe_n_o  <= 5'h1f;
            pc_din_o       <= 5'h00;
        end
        else
        begin
            pb_pin_o       <= pb_out_nxt;
            pb_pin_oe_n_o  <= pb_oe_n_nxt;
            pb_din_o       <= pb_pin_i;
            pb_hi_invert_o <= inv_r[15:8];
            pc_pin_o       <= pc_out_nxt;
            pc_pin_oe_n_o  <= pc_oe_n_nxt;
            pc_din_o       <= pc_pin_i;
        end
    end

    // ========================================================
    // Assertions
    // ========================================================
    pin7_oneshot_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (func_sel_r[15:14] == MODE_ONESHOT) |=>
        (pb_pin_o[7] == $past(tmr_i.ch8_oneshot[3] ^ inv_r[7]))
        && !pb_pin_oe_n_o[7])
        else $error("pin B7 one-shot output wrong");

    pin6_pwm_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (func_sel_r[13:12] == MODE_PWM) |=>
        (pb_pin_o[6] == $past(tmr_i.ch7_pwm[2] ^ inv_r[6])))
        else $error("pin B6 PWM output wrong");

    pin5_gpio_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (func_sel_r[11:10] == MODE_GPIO) |=>
        (pb_pin_o[5] == $past(pb_gpio_dout_i[5]))
        && (pb_pin_oe_n_o[5] == !$past(pb_gpio_dir_i[5])))
        else $error("pin B5 general I/O wrong");

    pin4_oneshot_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (func_sel_r[9:8] == MODE_ONESHOT) |=>
        (pb_pin_o[4] == $past(tmr_i.ch8_oneshot[0] ^ inv_r[4]))
        && !pb_pin_oe_n_o[4])
        else $error("pin B4 one-shot output wrong");

    pin0_pwm_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        func_sel_r[0] |=>
        (pb_pin_o[0] == $past(tmr_i.ch6_pwm[0] ^ inv_r[0])))
        else $error("pin B0 PWM output wrong");

    func_rsvd_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i.rd && (req_i.addr == OFS_B_FUNC) |=>
        ((rdata_o & ~B_FUNC_WMASK) == 16'h0000))
        else $error("reserved select bits read nonzero");

    inv_gap_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        $past(wr_hit(req_i, OFS_B_INV)) |-> !inv_r[INV_GAP_BIT])
        else $error("invert bit 12 stored");

    gpio_noinv_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !func_sel_r[4] && inv_r[2] |=>
        (pb_pin_o[2] == $past(pb_gpio_dout_i[2])))
        else $error("inversion applied to general I/O");

    pin3_inv_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        func_sel_r[6] |=>
        (pb_pin_o[3] == $past(tmr_i.ch6_pwm[3] ^ inv_r[3])))
        else $error("pin B3 not inverted");

    inv_clear_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hw_standby_i |=> (inv_r == REG_RST))
        else $error("invert register survived standby");

    dir_read_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i.rd && (req_i.addr == OFS_C_DIR) |=>
        (rdata_o[15:5] == 11'h000) && (rdata_o[4:0] == $past(dir_r[4:0])))
        else $error("port C direction read wrong");

    alt_ignore_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        pc_alt_func_i[1] && !pc_alt_drive_i[1] && dir_r[1] |=>
        pc_pin_oe_n_o[1])
        else $error("direction bit used for alternate pin");

    dir_drive_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !pc_alt_func_i[0] |=>
        (pc_pin_oe_n_o[0] == !$past(dir_r[0]))
        && (pc_pin_o[0] == $past(pc_gpio_dout_i[0])))
        else $error("port C direction not applied");

    dir_clear_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hw_standby_i |=> (dir_r == REG_RST))
        else $error("direction register survived standby");

    func_clear_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hw_standby_i |=> (func_sel_r == REG_RST) ##1 pb_pin_oe_n_o[3:0]
        == ~$past(pb_gpio_dir_i[3:0]))
        else $error("select register survived standby");

    wr_rd_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        wr_hit(req_i, OFS_B_INV) && !hw_standby_i
        ##1 req_i.rd && (req_i.addr == OFS_B_INV) |=>
        (rdata_o == ($past(req_i.wdata, 2) & B_INV_WMASK)))
        else $error("invert register read-back wrong");

endmodule : port_b_low_mux_invert_port_c_dir

// ---- design/pinmux_pkg.sv ----
// Shared types and constants for the port B low / port C pin block.
// Assumes a 16-bit register port with byte offsets on an 8-bit address.
package pinmux_pkg;

    // ========================================================
    // Register port
    // ========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    localparam logic [ADDR_W-1:0] OFS_B_FUNC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_B_INV  = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_C_DIR  = 8'h04;

    localparam logic [DATA_W-1:0] REG_RST      = 16'h0000;
    localparam logic [DATA_W-1:0] B_FUNC_WMASK = 16'hff55;
    localparam logic [DATA_W-1:0] B_INV_WMASK  = 16'hefff;
    localparam logic [DATA_W-1:0] C_DIR_WMASK  = 16'h001f;

    // ========================================================
    // Pin functions
    // ========================================================
    localparam int PB_PINS        = 8;
    localparam int PC_PINS        = 5;
    localparam int FUNC_STEP      = 2;
    localparam int WIDE_FIRST_PIN = 4;
    localparam int INV_GAP_BIT    = 12;

    localparam logic [1:0] MODE_GPIO    = 2'h0;
    localparam logic [1:0] MODE_PWM     = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;

    typedef enum logic [1:0] {
        FN_GPIO,
        FN_CH6_PWM,
        FN_CH7_PWM,
        FN_CH8_ONESHOT
    } pin_func_t;

    typedef struct packed {
        logic [3:0] ch6_pwm;
        logic [3:0] ch7_pwm;
        logic [3:0] ch8_oneshot;
    } timer_out_t;

endpackage : pinmux_pkg

// ---- dv/board_pins.sv ----
// Board model for the port B and port C pins of the pin block.
// Assumes active-low pin enables; released lines settle to the board level.
`timescale 1ns/100ps

module board_pins
(
    // Pin block side
    input  wire logic [7:0] pb_pin_o,
    input  wire logic [7:0] pb_pin_oe_n_o,
    input  wire logic [4:0] pc_pin_o,
    input  wire logic [4:0] pc_pin_oe_n_o,
    // Board levels on released lines
    input  wire logic [7:0] pb_ext_i,
    input  wire logic [4:0] pc_ext_i,
    // Levels seen by the pin block
    output logic      [7:0] pb_pin_i,
    output logic      [4:0] pc_pin_i
);
    // A released line shows the board level, never the last driven value.
    assign pb_pin_i = (pb_pin_o & ~pb_pin_oe_n_o) | (pb_ext_i & pb_pin_oe_n_o);
    assign pc_pin_i = (pc_pin_o & ~pc_pin_oe_n_o) | (pc_ext_i & pc_pin_oe_n_o);
endmodule : board_pins

// ---- dv/tb_port_b_low_mux_invert_port_c_dir.sv ----
// Self-checking bench for the port B low / port C pin block.
// Assumes the board model drives released pins low.
`timescale 1ns/100ps

module tb_port_b_low_mux_invert_port_c_dir;
    import pinmux_pkg::*;
    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] inv;
        timer_out_t  tmr;
        logic [7:0]  gd;
        logic [7:0]  gdir;
        logic [7:0]  exp_o;
        logic [7:0]  exp_oe_n;
    } row_t;
    // ========================================================
    // Signals
    // ========================================================
    logic       mclk_i, sys_rst_i, hw_standby_i;
    reg_req_t   req_i;
    logic [15:0] rdata_o;
    timer_out_t tmr_i;
    logic [7:0] pb_gpio_dout_i, pb_gpio_dir_i, pb_din_o, pb_hi_invert_o;
    logic [7:0] pb_pin_i, pb_pin_o, pb_pin_oe_n_o, pb_ext;
    logic [4:0] pc_alt_func_i, pc_alt_drive_i, pc_alt_dout_i, pc_gpio_dout_i;
    logic [4:0] pc_din_o, pc_pin_i, pc_pin_o, pc_pin_oe_n_o, pc_ext;
    int         miscompares, tests_run, cycles;
    row_t       rows [4] = '{
        '{16'h0000, 16'h00ff, 12'hfff, 8'ha5, 8'h0f, 8'ha5, 8'hf0},
        '{16'h5555, 16'h00a5, 12'h3c0, 8'h00, 8'h00, 8'h66, 8'h00},
        '{16'haa00, 16'h00f0, 12'hff9, 8'h0c, 8'h03, 8'h6c, 8'h0c},
        '{16'h6410, 16'h0084, 12'h4a0, 8'hff, 8'h0f, 8'h3b, 8'h10}};

    port_b_low_mux_invert_port_c_dir u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .hw_standby_i(hw_standby_i), .req_i(req_i), .rdata_o(rdata_o), .tmr_i(tmr_i),
        .pb_gpio_dout_i(pb_gpio_dout_i), .pb_gpio_dir_i(pb_gpio_dir_i), .pb_din_o(pb_din_o),
        .pb_hi_invert_o(pb_hi_invert_o), .pb_pin_i(pb_pin_i), .pb_pin_o(pb_pin_o),
        .pb_pin_oe_n_o(pb_pin_oe_n_o), .pc_alt_func_i(pc_alt_func_i),
        .pc_alt_drive_i(pc_alt_drive_i), .pc_alt_dout_i(pc_alt_dout_i),
        .pc_gpio_dout_i(pc_gpio_dout_i), .pc_din_o(pc_din_o), .pc_pin_i(pc_pin_i),
        .pc_pin_o(pc_pin_o), .pc_pin_oe_n_o(pc_pin_oe_n_o));

    board_pins u_board (.pb_pin_o(pb_pin_o), .pb_pin_oe_n_o(pb_pin_oe_n_o),
        .pc_pin_o(pc_pin_o), .pc_pin_oe_n_o(pc_pin_oe_n_o), .pb_ext_i(pb_ext),
        .pc_ext_i(pc_ext), .pb_pin_i(pb_pin_i), .pc_pin_i(pc_pin_i));

    // ========================================================
    // Tasks
    // ========================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req_i.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req_i.rd <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd_chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // ========================================================
    // Clock and timeout
    // ========================================================
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            final_report();
        end
    end

    // ========================================================
    // Main sequence
    // ========================================================
    initial
    begin
        {sys_rst_i, hw_standby_i, req_i, tmr_i, pb_gpio_dout_i, pb_gpio_dir_i} = '0;
        {pc_alt_func_i, pc_alt_drive_i, pc_alt_dout_i, pc_gpio_dout_i} = '0;
        {pb_ext, pc_ext, miscompares, tests_run, cycles} = '0;
        sys_rst_i = 1'b1;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        #1 chk(16'(pb_pin_oe_n_o), 16'h00ff);
        chk(16'(pc_pin_oe_n_o), 16'h001f);
        rd_chk(OFS_B_FUNC, REG_RST);
        rd_chk(OFS_B_INV, REG_RST);
        rd_chk(OFS_C_DIR, REG_RST);
        $display("test reset done");
        foreach (rows[i])
        begin
            @(posedge mclk_i);
            tmr_i <= rows[i].tmr;
            pb_gpio_dout_i <= rows[i].gd;
            pb_gpio_dir_i <= rows[i].gdir;
            wr(OFS_B_FUNC, rows[i].sel);
            wr(OFS_B_INV, rows[i].inv);
            rd_chk(OFS_B_FUNC, rows[i].sel);
            rd_chk(OFS_B_INV, rows[i].inv);
            chk(16'(pb_pin_o), 16'(rows[i].exp_o));
            chk(16'(pb_pin_oe_n_o), 16'(rows[i].exp_oe_n));
        end
        chk(16'(pb_din_o), 16'h002b);
        $display("test port b rows done");
        wr(OFS_B_INV, 16'hffff);
        rd_chk(OFS_B_INV, 16'hefff);
        chk(16'(pb_hi_invert_o), 16'h00ef);
        wr(OFS_C_DIR, 16'hffff);
        rd_chk(OFS_C_DIR, 16'h001f);
        rd_chk(8'h06, 16'h0000);
        @(posedge mclk_i);
        #1 chk(rdata_o, 16'h0000);
        $display("test read-only bits done");
        @(posedge mclk_i);
        pc_alt_func_i <= 5'h03;
        pc_alt_drive_i <= 5'h01;
        pc_alt_dout_i <= 5'h03;
        pc_gpio_dout_i <= 5'h1f;
        wr(OFS_C_DIR, 16'h0017);
        repeat (3) @(posedge mclk_i);
        #1 chk(16'(pc_pin_o), 16'h001f);
        chk(16'(pc_pin_oe_n_o), 16'h000a);
        chk(16'(pc_din_o), 16'h0015);
        $display("test port c done");
        // Standby must win over a write landing in the same cycle.
        @(posedge mclk_i);
        hw_standby_i <= 1'b1;
        req_i <= '{addr: OFS_B_INV, wdata: 16'h0001, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        hw_standby_i <= 1'b0;
        req_i.wr <= 1'b0;
        rd_chk(OFS_B_FUNC, REG_RST);
        rd_chk(OFS_B_INV, REG_RST);
        rd_chk(OFS_C_DIR, REG_RST);
        chk(16'(pb_hi_invert_o), 16'h0000);
        chk(16'(pc_pin_oe_n_o), 16'h001e);
        $display("test standby done");
        // A reset in mid-run must clear the select and invert registers and release every pin.
        wr(OFS_B_FUNC, 16'h5555);
        wr(OFS_B_INV, 16'h000f);
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        #1 chk(16'(pb_pin_o), 16'h00ab);
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1 chk(16'(pb_pin_oe_n_o), 16'h00ff);
        chk(16'(pc_pin_oe_n_o), 16'h001f);
        rd_chk(OFS_B_FUNC, REG_RST);
        rd_chk(OFS_B_INV, REG_RST);
        $display("test mid-run reset done");
        // A read straight after a write, with no idle cycle between them.
        @(posedge mclk_i);
        req_i <= '{addr: OFS_B_INV, wdata: 16'h1234, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req_i <= '{addr: OFS_B_INV, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req_i.rd <= 1'b0;
        #1 chk(rdata_o, 16'h0234);
        $display("test back-to-back done");
        final_report();
    end
endmodule : tb_port_b_low_mux_invert_port_c_dir
